// ---- src/dic_device.sv ----
// Purpose: converter input end: clock mode, interleave split, elastic store
// Assumes: link clocks are level inputs sampled on clk_sys, edges as enables
// Notes: pll modelled digitally; lock asserts after a settling count
`timescale 1ns/10ps
module dic_device
	import dic_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // sync reset
	dic_link_if.dev link, // link to data source
	input wire logic pll_supply_pin, // high means pll supply present
	input wire logic dual_clk_sel, // two-clock select
	input wire logic buffer_skip, // bypass elastic store
	input wire logic interleave_enable, // single-bus interleave
	input wire logic flag_select, // use flag pin for sequence
	input wire logic [1:0] prescale, // oscillator divide select
	input wire logic [1:0] fb_sel, // feedback divider select
	input wire logic [2:0] sync_src, // pointer init source
	input wire logic cfg_write, // serial config write pulse
	output logic [31:0] smp_data, // channel b,a sample out
	output logic smp_valid, // sample valid
	input wire logic smp_ready, // sample ready
	output logic [1:0] rd_ptr, // read pointer state
	output logic [1:0] wr_ptr, // write pointer state
	output dic_mode_t clk_mode, // current clock mode
	output logic smp_clk_en // derived sample-rate tick
);
	logic [15:0] rf_a [DIC_RF_SLOTS];
	logic [15:0] rf_b [DIC_RF_SLOTS];
	logic [DIC_RESET_W-1:0] rst_cnt_reg;
	logic dev_rst;
	logic dclk_d_reg, sclk_d_reg;
	logic dclk_rise, sclk_rise;
	logic [2:0] osc_div_reg;
	logic [2:0] fb_div_reg;
	logic osc_tick, fb_tick, in_tick, out_tick;
	logic [DIC_LOCK_W-1:0] lock_cnt_reg;
	logic [15:0] pa_reg, pb_reg;
	logic txen_reg, phs_reg, flg_reg;
	logic src_now_reg, src_d_reg, pa15_seen_reg;
	logic src_sel, sync_hit;
	logic chan_b_reg, txen_d_reg;
	logic [15:0] ch_a_reg;
	logic [1:0] wp_reg, rp_reg;
	logic [31:0] rd_word;
	logic fifo_in_ready, buf_push;
	// async pin reset stretched to a clean internal pulse
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rst_cnt_reg <= '0;
		else if (!link.reset_n)
			rst_cnt_reg <= DIC_RESET_W'(DIC_RESET_CYC);
		else if (rst_cnt_reg != '0)
			rst_cnt_reg <= rst_cnt_reg - 1'b1;
	end
	assign dev_rst = rst || (rst_cnt_reg != '0) || !link.reset_n;
	always_comb
	begin
		if (pll_supply_pin)
			clk_mode = DIC_MODE_PLL;
		else if (dual_clk_sel)
			clk_mode = DIC_MODE_DUAL;
		else
			clk_mode = DIC_MODE_EXT;
	end
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst)
		begin
			dclk_d_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
		end
		else
		begin
			dclk_d_reg <= link.data_rate_clock_in;
			sclk_d_reg <= link.sample_rate_clock_in;
		end
	end
	assign dclk_rise = link.data_rate_clock_in && !dclk_d_reg;
	// pll mode ignores the sample-rate pin entirely
	assign sclk_rise = link.sample_rate_clock_in && !sclk_d_reg &&
		(clk_mode != DIC_MODE_PLL);
	// oscillator model: every clk_sys edge is one oscillator tick
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst)
			osc_div_reg <= '0;
		else
			osc_div_reg <= osc_div_reg + 1'b1;
	end
	always_comb
	begin
		unique case (prescale)
			2'h0: osc_tick = 1'b1;
			2'h1: osc_tick = osc_div_reg[0];
			2'h2: osc_tick = &osc_div_reg[1:0];
			2'h3: osc_tick = &osc_div_reg;
		endcase
	end
	assign smp_clk_en = (clk_mode == DIC_MODE_PLL) ? osc_tick : sclk_rise;
	// no-buffer dual mode: data clock edge rephases the divider;
	// interleave plus pll leaves it free running
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst)
			fb_div_reg <= '0;
		else if (clk_mode == DIC_MODE_DUAL && buffer_skip && dclk_rise)
			fb_div_reg <= '0;
		else if (smp_clk_en)
			fb_div_reg <= fb_div_reg + 1'b1;
	end
	always_comb
	begin
		unique case (fb_sel)
			2'h0: fb_tick = smp_clk_en;
			2'h1: fb_tick = smp_clk_en && fb_div_reg[0];
			2'h2: fb_tick = smp_clk_en && (&fb_div_reg[1:0]);
			2'h3: fb_tick = smp_clk_en && (&fb_div_reg);
		endcase
	end
	// lock counts data-rate clock rising edges in pll mode; feedback ticks play no part
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst || clk_mode != DIC_MODE_PLL)
			lock_cnt_reg <= '0;
		else if (dclk_rise && lock_cnt_reg != DIC_LOCK_W'(DIC_LOCK_CYCLES))
			lock_cnt_reg <= lock_cnt_reg + 1'b1;
	end
	assign link.pll_lock = (clk_mode == DIC_MODE_PLL) &&
		(lock_cnt_reg == DIC_LOCK_W'(DIC_LOCK_CYCLES));
	// input side always latches on the data-rate clock
	assign in_tick = dclk_rise;
	assign out_tick = buffer_skip ? in_tick : fb_tick;
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst)
		begin
			pa_reg <= '0;
			pb_reg <= '0;
			txen_reg <= 1'b0;
			phs_reg <= 1'b0;
			flg_reg <= 1'b0;
		end
		else if (in_tick)
		begin
			pa_reg <= link.port_a_data;
			pb_reg <= link.port_b_data;
			txen_reg <= link.transmit_enable_pin;
			phs_reg <= link.phase_strobe;
			flg_reg <= link.chan_flag;
		end
	end
	always_comb
	begin
		unique case (sync_src)
			DIC_SYNC_TXEN: src_sel = txen_reg;
			DIC_SYNC_PHSTR: src_sel = phs_reg;
			DIC_SYNC_QFLAG: src_sel = flg_reg;
			DIC_SYNC_PB15: src_sel = pb_reg[15];
			DIC_SYNC_PA15: src_sel = pa_reg[15] && !pa15_seen_reg;
			DIC_SYNC_OFF: src_sel = 1'b0;
			DIC_SYNC_NOW5, DIC_SYNC_NOW7: src_sel = 1'b0;
		endcase
	end
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst)
		begin
			src_now_reg <= 1'b0;
			src_d_reg <= 1'b0;
			pa15_seen_reg <= 1'b0;
		end
		else if (in_tick)
		begin
			src_now_reg <= src_sel;
			src_d_reg <= src_now_reg;
			if (sync_src == DIC_SYNC_PA15 && src_now_reg && !src_d_reg)
				pa15_seen_reg <= 1'b1;
		end
	end
	// serial write syncs at once, regardless of data clock, only with sync_src 5 or 7
	assign sync_hit = (in_tick && src_now_reg && !src_d_reg) ||
		(cfg_write && (sync_src == DIC_SYNC_NOW5 ||
		sync_src == DIC_SYNC_NOW7));
	// fifo push and read pointer wait while the fifo is full; the store write pointer keeps stepping
	assign buf_push = out_tick && fifo_in_ready;
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst)
		begin
			wp_reg <= DIC_WPTR_INIT;
			rp_reg <= DIC_RPTR_INIT;
		end
		else if (sync_hit)
		begin
			wp_reg <= DIC_WPTR_INIT;
			rp_reg <= DIC_RPTR_INIT;
		end
		else
		begin
			if (in_tick)
				wp_reg <= wp_reg + 2'h1;
			if (buf_push)
				rp_reg <= rp_reg + 2'h1;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (in_tick)
		begin
			rf_a[wp_reg] <= link.port_a_data;
			rf_b[wp_reg] <= link.port_b_data;
		end
	end
	assign rd_word = buffer_skip ? {pb_reg, pa_reg} :
		{rf_b[rp_reg], rf_a[rp_reg]};
	assign rd_ptr = rp_reg;
	assign wr_ptr = wp_reg;
	// interleave: pair a then b words from port a into one sample
	always_ff @(posedge clk_sys)
	begin
		if (dev_rst)
		begin
			chan_b_reg <= 1'b0;
			txen_d_reg <= 1'b0;
			ch_a_reg <= '0;
		end
		else if (in_tick)
		begin
			txen_d_reg <= link.transmit_enable_pin;
			if (flag_select)
				chan_b_reg <= !link.chan_flag;
			else if (link.transmit_enable_pin && !txen_d_reg)
				chan_b_reg <= 1'b1;
			else
				chan_b_reg <= !chan_b_reg;
			// without flag_select, the word at an enable rise is always a, whatever the toggle
			if (flag_select ? !link.chan_flag :
				(!chan_b_reg || (link.transmit_enable_pin && !txen_d_reg)))
				ch_a_reg <= link.port_a_data;
		end
	end
	logic il_push;
	logic [31:0] fifo_in;
	assign il_push = in_tick && (flag_select ? link.chan_flag :
		(chan_b_reg && !(link.transmit_enable_pin && !txen_d_reg)));
	assign fifo_in = interleave_enable ? {link.port_a_data, ch_a_reg} :
		rd_word;
	dic_fifo #(.WIDTH(32), .DEPTH(DIC_FIFO_D)) u_fifo (
		.clk_sys(clk_sys),
		.rst(dev_rst),
		.in_data(fifo_in),
		.in_valid(interleave_enable ? il_push : buf_push),
		.in_ready(fifo_in_ready),
		.out_data(smp_data),
		.out_valid(smp_valid),
		.out_ready(smp_ready)
	);
endmodule

// ---- src/dic_fifo.sv ----
// Purpose: valid/ready fifo with parameterised width and depth
// Assumes: depth is a power of two
// Notes: one extra pointer bit gives honest full and empty
`timescale 1ns/10ps
module dic_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // sync reset
	input wire logic [WIDTH-1:0] in_data, // fill data
	input wire logic in_valid, // fill valid
	output logic in_ready, // not full
	output logic [WIDTH-1:0] out_data, // drain data
	output logic out_valid, // not empty
	input wire logic out_ready // drain ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_reg;
	logic [AW:0] rp_reg;
	logic push;
	logic pop;
	assign in_ready = (wp_reg[AW-1:0] != rp_reg[AW-1:0]) ||
		(wp_reg[AW] == rp_reg[AW]);
	assign out_valid = wp_reg != rp_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rp_reg[AW-1:0]];
	always_ff @(posedge clk_sys)
	begin
		if (push)
		begin
			mem[wp_reg[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wp_reg <= wp_reg + 1'b1;
			end
			if (pop)
			begin
				rp_reg <= rp_reg + 1'b1;
			end
		end
	end
endmodule

// ---- src/dic_link_if.sv ----
// Purpose: link between data source and converter input end
// Assumes: all signals synchronous to clk_sys
// Notes: one modport per party
`timescale 1ns/10ps
interface dic_link_if;
	logic [15:0] port_a_data;
	logic [15:0] port_b_data;
	logic transmit_enable_pin;
	logic phase_strobe;
	logic chan_flag;
	logic data_rate_clock_in;
	logic sample_rate_clock_in;
	logic pll_lock;
	logic reset_n;
	modport dev (input port_a_data, input port_b_data,
		input transmit_enable_pin, input phase_strobe, input chan_flag,
		input data_rate_clock_in, input sample_rate_clock_in,
		output pll_lock, input reset_n);
	modport src (output port_a_data, output port_b_data,
		output transmit_enable_pin, output phase_strobe, output chan_flag,
		output data_rate_clock_in, output sample_rate_clock_in,
		input pll_lock, output reset_n);
endinterface

// ---- src/dic_pkg.sv ----
// Purpose: shared constants for the converter input clocking and buffer
// Assumes: single 100 MHz system clock, synchronous active-high reset
// Notes: sample-rate and data-rate clocks arrive as levels on clk_sys; their edges act as enables
package dic_pkg;
	localparam int DIC_DATA_W = 16;
	localparam int DIC_FIFO_D = 8;
	localparam int DIC_RF_SLOTS = 4;
	localparam logic [1:0] DIC_WPTR_INIT = 2'h0;
	localparam logic [1:0] DIC_RPTR_INIT = 2'h2;
	localparam logic [2:0] DIC_SYNC_TXEN = 3'h0;
	localparam logic [2:0] DIC_SYNC_PHSTR = 3'h1;
	localparam logic [2:0] DIC_SYNC_QFLAG = 3'h2;
	localparam logic [2:0] DIC_SYNC_PB15 = 3'h3;
	localparam logic [2:0] DIC_SYNC_PA15 = 3'h4;
	localparam logic [2:0] DIC_SYNC_NOW5 = 3'h5;
	localparam logic [2:0] DIC_SYNC_OFF = 3'h6;
	localparam logic [2:0] DIC_SYNC_NOW7 = 3'h7;
	localparam logic [2:0] DIC_SYNC_RST = 3'h6;
	localparam logic [1:0] DIC_PRESCALE_RST = 2'h0;
	localparam logic [1:0] DIC_FBSEL_RST = 2'h1;
	localparam int DIC_LOCK_CYCLES = 16;
	localparam int DIC_LOCK_W = 5;
	localparam int DIC_CLK_MHZ = 100;
	localparam int DIC_RESET_NS = 50;
	localparam int DIC_RESET_CYC = (DIC_RESET_NS * DIC_CLK_MHZ + 999) / 1000 + 1;
	localparam int DIC_RESET_W = 4;
	typedef enum logic [1:0] {DIC_MODE_EXT, DIC_MODE_PLL, DIC_MODE_DUAL}
		dic_mode_t;
endpackage

// ---- src/dic_source.sv ----
// Purpose: data source end driving sample words and clocks onto the link
// Assumes: user supplies words with valid/ready
// Notes: clocks generated by dividing clk_sys; reset pulse stops the clock
`timescale 1ns/10ps
module dic_source
	import dic_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // sync reset
	dic_link_if.src link, // link to converter
	input wire logic [15:0] usr_a, // word for port a
	input wire logic [15:0] usr_b, // word for port b
	input wire logic usr_valid, // word valid
	output logic usr_ready, // word taken
	input wire logic usr_txen, // transmit enable level
	input wire logic usr_phstr, // phase strobe level
	input wire logic usr_flag, // channel flag level
	input wire logic usr_sync_rst, // request divider reset
	output logic usr_locked // lock seen
);
	import dic_pkg::*;
	logic dclk_reg, sclk_reg;
	logic [DIC_RESET_W-1:0] rcnt_reg;
	logic [15:0] a_reg, b_reg;
	logic tx_reg, ph_reg, fl_reg;
	logic busy;
	// clock held low during reset; both clocks share edges, so aligned
	assign busy = rcnt_reg != '0;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rcnt_reg <= '0;
		else if (usr_sync_rst && !busy)
			rcnt_reg <= DIC_RESET_W'(DIC_RESET_CYC);
		else if (busy)
			rcnt_reg <= rcnt_reg - 1'b1;
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst || busy)
		begin
			dclk_reg <= 1'b0;
			sclk_reg <= 1'b0;
		end
		else
		begin
			dclk_reg <= !dclk_reg;
			sclk_reg <= !sclk_reg;
		end
	end
	// new word presented while the data clock is low
	assign usr_ready = dclk_reg && !busy;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			a_reg <= '0;
			b_reg <= '0;
			tx_reg <= 1'b0;
			ph_reg <= 1'b0;
			fl_reg <= 1'b0;
		end
		else if (usr_ready && usr_valid)
		begin
			a_reg <= usr_a;
			b_reg <= usr_b;
			tx_reg <= usr_txen;
			ph_reg <= usr_phstr;
			fl_reg <= usr_flag;
		end
	end
	assign link.port_a_data = a_reg;
	assign link.port_b_data = b_reg;
	assign link.transmit_enable_pin = tx_reg;
	assign link.phase_strobe = ph_reg;
	assign link.chan_flag = fl_reg;
	assign link.data_rate_clock_in = dclk_reg;
	assign link.sample_rate_clock_in = sclk_reg;
	assign link.reset_n = !busy;
	assign usr_locked = link.pll_lock;
endmodule

// ---- tb/dic_link_props.sv ----
// Purpose: link and mode checks for the source and converter pair
// Assumes: every signal sampled on clk_sys
// Notes: watches the link plus a few device outputs
`timescale 1ns/10ps
module dic_link_props
	import dic_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // sync reset
	input wire logic data_rate_clock_in, // data clock level
	input wire logic pll_lock, // lock from device
	input wire logic reset_n, // reset from source
	input wire logic pll_supply_pin, // supply level
	input wire logic dual_clk_sel, // two-clock select
	input dic_mode_t clk_mode, // decoded mode
	input wire logic [1:0] wr_ptr, // write pointer
	input wire logic [1:0] rd_ptr // read pointer
);
	int unsigned edge_cnt;
	logic clk_d;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	always_ff @(posedge clk_sys)
	begin
		clk_d <= data_rate_clock_in;
	end
	// saturates so a long run cannot wrap the count
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			edge_cnt <= 0;
		else if (data_rate_clock_in && !clk_d && edge_cnt < 1000)
			edge_cnt <= edge_cnt + 1;
	end
	lock_reset_low_a: assert property (disable iff (1'b0)
		rst |=> !pll_lock) else $error("lock high after reset");
	lock_needs_edges_a: assert property (
		$rose(pll_lock) |-> edge_cnt >= DIC_LOCK_CYCLES)
		else $error("lock rose too early");
	mode_pll_a: assert property (
		pll_supply_pin |-> clk_mode == DIC_MODE_PLL)
		else $error("supply high without pll mode");
	mode_dual_a: assert property (
		!pll_supply_pin && dual_clk_sel |-> clk_mode == DIC_MODE_DUAL)
		else $error("dual mode not entered");
	ptr_reset_a: assert property (disable iff (1'b0)
		rst |=> wr_ptr == DIC_WPTR_INIT && rd_ptr == DIC_RPTR_INIT)
		else $error("pointers not at start slots");
	wr_step_a: assert property ($changed(wr_ptr) |->
		wr_ptr == $past(wr_ptr) + 2'h1 || wr_ptr == DIC_WPTR_INIT)
		else $error("write pointer jumped");
	rd_step_a: assert property ($changed(rd_ptr) |->
		rd_ptr == $past(rd_ptr) + 2'h1 || rd_ptr == DIC_RPTR_INIT)
		else $error("read pointer jumped");
	reset_hold_a: assert property (
		$fell(reset_n) |-> (!reset_n) [*6])
		else $error("link reset too short");
	clock_stop_a: assert property (
		!reset_n && !$past(reset_n) |-> $stable(data_rate_clock_in))
		else $error("data clock ran during reset");
	clock_idle_a: assert property (disable iff (1'b0)
		rst |=> !data_rate_clock_in) else $error("data clock in reset");
	cover property ($rose(pll_lock));
	cover property ($fell(reset_n));
	cover property (clk_mode == DIC_MODE_DUAL);
endmodule

// ---- tb/test_dac_input_clocking_and_fifo.sv ----
// Purpose: end-to-end bench for the source and converter input pair
// Assumes: both ends on clk_sys, joined by the link interface
// Notes: device samples every data edge, so expected words are searched
`timescale 1ns/10ps
module test_dac_input_clocking_and_fifo;
	import dic_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic pll_supply_pin = 1'b1, dual_clk_sel = 1'b1, buffer_skip = 1'b1;
	logic interleave_enable = 1'b0, flag_select = 1'b0, cfg_write = 1'b0;
	logic [1:0] prescale = DIC_PRESCALE_RST, fb_sel = DIC_FBSEL_RST;
	logic [2:0] sync_src = DIC_SYNC_RST;
	logic smp_ready = 1'b1, smp_valid, usr_ready, usr_locked;
	logic [31:0] smp_data;
	logic [1:0] rd_ptr, wr_ptr;
	dic_mode_t clk_mode;
	logic [15:0] usr_a = 16'h0, usr_b = 16'h0;
	logic usr_valid = 1'b0, usr_txen = 1'b0, usr_phstr = 1'b0;
	logic usr_flag = 1'b0, usr_sync_rst = 1'b0;
	logic [2:0] srcs [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
	logic [31:0] got [$], exp_q [$];
	int miscompares = 0, check_count = 0;
	always #5 clk_sys = ~clk_sys;
	dic_link_if dic_link_if_inst ();
	dic_device dic_device_inst (.clk_sys, .rst,
		.link(dic_link_if_inst.dev), .pll_supply_pin, .dual_clk_sel,
		.buffer_skip, .interleave_enable, .flag_select, .prescale, .fb_sel,
		.sync_src, .cfg_write, .smp_data, .smp_valid, .smp_ready, .rd_ptr,
		.wr_ptr, .clk_mode, .smp_clk_en());
	dic_source dic_source_inst (.clk_sys, .rst,
		.link(dic_link_if_inst.src), .usr_a, .usr_b, .usr_valid, .usr_ready,
		.usr_txen, .usr_phstr, .usr_flag, .usr_sync_rst, .usr_locked);
	dic_link_props dic_link_props_inst (.clk_sys, .rst,
		.data_rate_clock_in(dic_link_if_inst.data_rate_clock_in),
		.pll_lock(dic_link_if_inst.pll_lock),
		.reset_n(dic_link_if_inst.reset_n), .pll_supply_pin,
		.dual_clk_sel, .clk_mode, .wr_ptr, .rd_ptr);
	// outputs settle by the falling edge, before the next pop
	always @(negedge clk_sys)
		if (!rst && smp_valid === 1'b1 && smp_ready === 1'b1)
			got.push_back(smp_data);
	task tick(input int n = 1);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task cmp_word(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %0t word %h expected %h", $time, g, e);
		end
	endtask
	task cmp_bit(input logic g, input logic e);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %0t flag %b expected %b", $time, g, e);
		end
	endtask
	task cmp_mode(input dic_mode_t g, input dic_mode_t e);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %0t mode %0d expected %0d", $time, g, e);
		end
	endtask
	// holds the word until the edge where ready is high
	task send(input logic [15:0] a, input logic [15:0] b, input logic f);
		int n;
		usr_a = a;
		usr_b = b;
		usr_flag = f;
		usr_valid = 1'b1;
		n = 0;
		while (usr_ready !== 1'b1 && n < 20)
		begin
			tick();
			n++;
		end
		tick();
	endtask
	task drain();
		int n;
		logic [31:0] e;
		usr_valid = 1'b0;
		n = 0;
		while (n < 200 && !(got.size() > 0 && got[$] === exp_q[$]))
		begin
			tick();
			n++;
		end
		while (exp_q.size() > 0)
		begin
			e = exp_q.pop_front();
			while (got.size() > 0 && got[0] !== e)
				void'(got.pop_front());
			cmp_word(got.size() > 0 ? got[0] : 32'hx, e);
		end
		got.delete();
	endtask
	task wait_lock();
		int n;
		n = 0;
		while (usr_locked !== 1'b1 && n < 400)
		begin
			tick();
			n++;
		end
		cmp_bit(usr_locked, 1'b1);
	endtask
	task wait_init();
		int n;
		n = 0;
		while (!(wr_ptr === DIC_WPTR_INIT && rd_ptr === DIC_RPTR_INIT)
			&& n < 8)
		begin
			tick();
			n++;
		end
		cmp_bit(wr_ptr === DIC_WPTR_INIT, 1'b1);
		cmp_bit(rd_ptr === DIC_RPTR_INIT, 1'b1);
	endtask
	initial
	begin
		tick(10);
		rst = 1'b0;
		tick();
		cmp_mode(clk_mode, DIC_MODE_PLL);
		wait_lock();
		for (int i = 0; i < 4; i++)
		begin
			prescale = 2'(i);
			fb_sel = 2'(i);
			tick();
			send(16'h1a00 + 16'(i), 16'h2b00 + 16'(i), 1'b0);
			send(16'h1c00 + 16'(i), 16'h2d00 + 16'(i), 1'b0);
			exp_q.push_back({16'h2b00 + 16'(i), 16'h1a00 + 16'(i)});
			exp_q.push_back({16'h2d00 + 16'(i), 16'h1c00 + 16'(i)});
			drain();
		end
		interleave_enable = 1'b1;
		flag_select = 1'b1;
		send(16'h5a01, 16'h0, 1'b0);
		send(16'h5b01, 16'h0, 1'b1);
		exp_q.push_back({16'h5b01, 16'h5a01});
		drain();
		flag_select = 1'b0;
		tick();
		usr_txen = 1'b1;
		send(16'h6a01, 16'h0, 1'b0);
		send(16'h6b01, 16'h0, 1'b0);
		exp_q.push_back({16'h6b01, 16'h6a01});
		drain();
		interleave_enable = 1'b0;
		pll_supply_pin = 1'b0;
		for (int d = 0; d < 2; d++)
		begin
			dual_clk_sel = d[0];
			tick();
			cmp_mode(clk_mode, d ? DIC_MODE_DUAL : DIC_MODE_EXT);
		end
		buffer_skip = 1'b0;
		// source only latches levels while a word is offered
		usr_valid = 1'b1;
		// pointer init only here, after the streamed word checks are done
		foreach (srcs[k])
		begin
			sync_src = srcs[k];
			usr_txen = 1'b0;
			usr_phstr = 1'b0;
			usr_flag = 1'b0;
			usr_a = 16'h0;
			usr_b = 16'h0;
			tick(4);
			// every candidate rises at once; only the chosen one counts
			usr_txen = 1'b1;
			usr_phstr = 1'b1;
			usr_flag = 1'b1;
			usr_a = 16'h8000;
			usr_b = 16'h8000;
			cfg_write = 1'b1;
			tick();
			cfg_write = 1'b0;
			wait_init();
		end
		usr_valid = 1'b0;
		pll_supply_pin = 1'b1;
		buffer_skip = 1'b1;
		usr_sync_rst = 1'b1;
		tick();
		usr_sync_rst = 1'b0;
		tick(20);
		wait_lock();
		complete_run();
	end
	initial
	begin
		#100000;
		miscompares++;
		complete_run();
	end
endmodule
